// ==== hdl/fbc_pkg.sv ====
// constants, types and register map of the feedback conditioning block
// Summary of operation
// [RL1] a raw feedback below the lower error threshold (reset 0) flags a disconnect.
// [RL2] a raw feedback above the upper error threshold (reset 4095) flags a disconnect.
// [RL3] the scaled feedback maps the lower..upper scaling bounds (0..4095) onto 0..4095.
// [RL4] the invert option bit 2 reverses the scaled feedback direction.
// [RL5] the detect option bit 3 drives the sense-power pin low.
// [RL6] with PID active an error smaller than the dead zone zeroes the duty and the integral.
// [RL7] analog mode averages two to the exponent (0..10, reset 7) samples per period.
// [RL8] the wraparound option bit 4 makes scaled 0 and 4095 neighbours in analog mode.
// [RL9] mode 0 disables feedback, 1 selects analog, 2 selects frequency feedback.
// [RL10] analog samples map 0 V to 0 and full scale to 4092.
// [RL11] checks, scaling and dead zone run once per period on that period's raw value.
package fbc_pkg;
    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_OPTIONS = 8'h02;
    localparam logic [7:0] IDX_MODE = 8'h18;
    localparam logic [7:0] IDX_ERR_LO = 8'h19;
    localparam logic [7:0] IDX_ERR_HI = 8'h1B;
    localparam logic [7:0] IDX_SCALE_LO = 8'h1D;
    localparam logic [7:0] IDX_SCALE_HI = 8'h1F;
    localparam logic [7:0] IDX_DEAD_ZONE = 8'h21;
    localparam logic [7:0] IDX_SAMPLE_EXP = 8'h22;
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam logic [7:0] IDX_MASK = 8'h31;
    localparam logic [7:0] IDX_TARGET = 8'h32;
    localparam logic [7:0] IDX_RAW = 8'h33;
    localparam logic [7:0] IDX_SCALED = 8'h34;
    localparam logic [7:0] IDX_PID_ERR = 8'h35;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int OPT_INVERT = 2;
    localparam int OPT_DETECT = 3;
    localparam int OPT_WRAP = 4;
    localparam int STAT_DISC = 0;
    localparam int STAT_DONE = 1;
    localparam logic [7:0] RST_OPTIONS = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [15:0] RST_ERR_LO = 16'h0000;
    localparam logic [15:0] RST_ERR_HI = 16'h0FFF;
    localparam logic [15:0] RST_SCALE_LO = 16'h0000;
    localparam logic [15:0] RST_SCALE_HI = 16'h0FFF;
    localparam logic [7:0] RST_DEAD_ZONE = 8'h00;
    localparam logic [7:0] RST_SAMPLE_EXP = 8'h07;
    localparam logic [11:0] RST_TARGET = 12'h800;
    localparam logic [7:0] MODE_NONE = 8'h00;
    localparam logic [7:0] MODE_ANALOG = 8'h01;
    localparam logic [7:0] MODE_FREQ = 8'h02;
    localparam logic [11:0] FB_FULL = 12'hFFF;
    localparam logic [11:0] RAW_FULL = 12'hFFC;
    localparam logic [3:0] EXP_MAX = 4'hA;
    localparam logic [12:0] ERR_HALF = 13'h0800;
    localparam logic [12:0] ERR_WRAP = 13'h1000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_EVAL = 2'b10
    } fbc_st_t;

    typedef struct packed {
        fbc_st_t st;
        logic [7:0] opt;
        logic [7:0] mode;
        logic [15:0] err_lo;
        logic [15:0] err_hi;
        logic [15:0] sc_lo;
        logic [15:0] sc_hi;
        logic [7:0] dz;
        logic [7:0] exp;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [11:0] target;
        logic [11:0] raw;
        logic [11:0] scaled;
        logic [12:0] pid_err;
        logic disc;
        logic duty_zero;
        logic int_clr;
        logic irq;
        logic aux_oe_n;
        logic aux_out;
        logic start;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] hrdata;
        logic rdy;
    } fbc_state_t;

    typedef struct packed {
        logic busy;
        logic [3:0] exp;
        logic [10:0] cnt;
        logic [21:0] sum;
        logic done;
        logic [11:0] avg;
    } fbc_avg_state_t;
endpackage

// ==== hdl/fbc_avg_if.sv ====
// carrier between the controller and the sample averager
interface fbc_avg_if;
    logic start;
    logic [3:0] exp;
    logic done;
    logic [11:0] avg;
    modport ctrl (output start, exp, input done, avg);
    modport unit (input start, exp, output done, avg);
endinterface

// ==== hdl/fbc_averager.sv ====
// sample accumulator that averages a power-of-two number of samples
module fbc_averager import fbc_pkg::*; #(
    parameter int MAX_EXP = 10
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic adc_valid,
    input wire logic [9:0] adc_code,
    fbc_avg_if.unit u
);
    if (MAX_EXP > 10 || MAX_EXP < 0) begin : g_chk
        $error("averager holds at most 1024 samples");
    end

    fbc_avg_state_t r, n;
    logic [21:0] sum_n;
    logic [10:0] cnt_n;

    // accumulate raw codes, scaled so that full scale lands on 4092
    always_comb begin
        n = r;
        n.done = 1'b0;
        sum_n = r.sum + {10'h000, adc_code, 2'b00}; // RL10
        cnt_n = r.cnt + 11'h001;
        if (u.start) begin
            n.busy = 1'b1;
            n.exp = u.exp;
            n.cnt = 11'h000;
            n.sum = 22'h000000;
        end else if (r.busy && adc_valid) begin
            n.sum = sum_n;
            n.cnt = cnt_n;
            // count of two to the exponent closes the average
            if (cnt_n == (11'h001 << r.exp)) begin // RL7
                n.busy = 1'b0;
                n.done = 1'b1;
                n.avg = 12'(sum_n >> r.exp);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign u.done = r.done;
    assign u.avg = r.avg;

    a_avg_close: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && r.busy && !u.start && adc_valid
        && (r.cnt + 11'h001 == (11'h001 << r.exp)) |=> u.done) // RL7
        else $error("average did not close at the sample count");
    // only a single-sample average keeps the step of four; longer averages land in between
    a_avg_range: assert property (@(posedge ref_clk) disable iff (reset)
        u.done |-> (u.avg <= RAW_FULL) && (r.exp != 4'h0 || u.avg[1:0] == 2'b00)) // RL10
        else $error("averaged raw value out of range");
endmodule

// ==== hdl/fbc_scaler.sv ====
// feedback scaling, inversion, wraparound error and dead zone
module fbc_scaler import fbc_pkg::*; (
    input wire logic [11:0] raw,
    input wire logic [15:0] lo,
    input wire logic [15:0] hi,
    input wire logic invert,
    input wire logic wrap,
    input wire logic [11:0] target,
    input wire logic [7:0] dead_zone,
    output logic [11:0] scaled,
    output logic [12:0] error,
    output logic in_dead
);
    logic [11:0] lin;
    logic [23:0] prod;
    logic [12:0] diff;
    logic [12:0] mag;

    // linear map of lo..hi onto the full scale, clamped at both ends
    always_comb begin
        prod = 24'(({4'h0, raw} - lo) * FB_FULL);
        if ({4'h0, raw} <= lo || hi <= lo) begin // RL3
            lin = 12'h000;
        end else if ({4'h0, raw} >= hi) begin
            lin = FB_FULL;
        end else begin
            lin = 12'(prod / 24'(hi - lo));
        end
        scaled = invert ? (FB_FULL - lin) : lin; // RL4
    end

    // signed error; wraparound folds it into the short way round
    always_comb begin
        diff = {1'b0, target} - {1'b0, scaled};
        if (wrap && !diff[12] && diff > ERR_HALF) begin // RL8
            diff = diff - ERR_WRAP;
        end else if (wrap && diff[12] && (13'h0000 - diff) > ERR_HALF) begin
            diff = diff + ERR_WRAP;
        end
        mag = diff[12] ? (13'h0000 - diff) : diff;
        in_dead = mag < {5'h00, dead_zone}; // RL6
        error = in_dead ? 13'h0000 : diff;
    end
endmodule

// ==== hdl/fbc_top.sv ====
// feedback conditioning controller with its ahb-lite register slave
module fbc_top import fbc_pkg::*; #(
    parameter int MAX_EXP = 10
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic pid_tick,
    input wire logic adc_valid,
    input wire logic [9:0] adc_code,
    input wire logic [11:0] freq_value,
    output logic aux_pin_out,
    output logic aux_pin_oe_n,
    output logic fb_disconnect,
    output logic duty_zero,
    output logic integral_clear,
    output logic [12:0] pid_error,
    output logic [11:0] scaled_fb,
    output logic irq
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (MAX_EXP != 10) begin : g_chk
        $error("sample exponent range is fixed at 0 to 10");
    end

    // ------------------------------------------------------------
    // state and submodules
    // ------------------------------------------------------------
    fbc_state_t r, n;
    fbc_avg_if avg_bus ();
    logic [11:0] sc_scaled;
    logic [12:0] sc_error;
    logic sc_dead;
    logic addr_ok;
    logic [3:0] exp_eff;

    fbc_averager #(
        .MAX_EXP(MAX_EXP)
    ) u_avg (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .adc_valid(adc_valid),
        .adc_code(adc_code),
        .u(avg_bus)
    );

    fbc_scaler u_scale (
        .raw(r.raw),
        .lo(r.sc_lo),
        .hi(r.sc_hi),
        .invert(r.opt[OPT_INVERT]),
        .wrap(r.opt[OPT_WRAP] && r.mode == MODE_ANALOG),
        .target(r.target),
        .dead_zone(r.dz),
        .scaled(sc_scaled),
        .error(sc_error),
        .in_dead(sc_dead)
    );

    // exponents above ten are clamped rather than overflowing the count
    assign exp_eff = (r.exp > {4'h0, EXP_MAX}) ? EXP_MAX : r.exp[3:0];
    assign avg_bus.start = r.start;
    assign avg_bus.exp = exp_eff;

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] read_reg(input logic [7:0] idx, input fbc_state_t s);
        logic [31:0] v;
        v = 32'h00000000;
        case (idx)
            IDX_OPTIONS: v = {24'h000000, s.opt};
            IDX_MODE: v = {24'h000000, s.mode};
            IDX_ERR_LO: v = {16'h0000, s.err_lo};
            IDX_ERR_HI: v = {16'h0000, s.err_hi};
            IDX_SCALE_LO: v = {16'h0000, s.sc_lo};
            IDX_SCALE_HI: v = {16'h0000, s.sc_hi};
            IDX_DEAD_ZONE: v = {24'h000000, s.dz};
            IDX_SAMPLE_EXP: v = {24'h000000, s.exp};
            IDX_STATUS: v = {30'h00000000, s.stat};
            IDX_MASK: v = {30'h00000000, s.mask};
            IDX_TARGET: v = {20'h00000, s.target};
            IDX_RAW: v = {20'h00000, s.raw};
            IDX_SCALED: v = {20'h00000, s.scaled};
            IDX_PID_ERR: v = {19'h00000, s.pid_err};
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    // upper address bits must be zero, so aliases read as zero
    assign addr_ok = (haddr[31:10] == 22'h000000);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.start = 1'b0;
        n.int_clr = 1'b0;
        n.rdy = 1'b1;
        // data phase of a write; unmapped indices are dropped
        if (r.wr_pend) begin
            case (r.wr_idx)
                IDX_OPTIONS: n.opt = hwdata[7:0];
                IDX_MODE: n.mode = hwdata[7:0];
                IDX_ERR_LO: n.err_lo = hwdata[15:0];
                IDX_ERR_HI: n.err_hi = hwdata[15:0];
                IDX_SCALE_LO: n.sc_lo = hwdata[15:0];
                IDX_SCALE_HI: n.sc_hi = hwdata[15:0];
                IDX_DEAD_ZONE: n.dz = hwdata[7:0];
                IDX_SAMPLE_EXP: n.exp = hwdata[7:0];
                IDX_STATUS: n.stat = r.stat & ~hwdata[1:0];
                IDX_MASK: n.mask = hwdata[1:0];
                IDX_TARGET: n.target = hwdata[11:0];
                default: n.wr_pend = 1'b0;
            endcase
        end
        n.wr_pend = 1'b0;
        // address phase; read data is taken after a pending write lands
        if (hsel && hready && htrans[1]) begin
            n.wr_pend = hwrite;
            n.wr_idx = addr_ok ? haddr[9:2] : 8'hFF;
            if (!hwrite) begin
                n.hrdata = addr_ok ? read_reg(haddr[9:2], n) : 32'h00000000;
            end
        end
        // detect option pulls the sense-power pin low
        n.aux_out = 1'b0;
        n.aux_oe_n = ~n.opt[OPT_DETECT]; // RL5
        // one pass of the conditioning sequence per period
        case (r.st)
            ST_IDLE: begin
                if (pid_tick) begin
                    case (r.mode) // RL9
                        MODE_ANALOG: begin
                            n.start = 1'b1;
                            n.st = ST_SAMPLE;
                        end
                        MODE_FREQ: begin
                            n.raw = freq_value;
                            n.st = ST_EVAL;
                        end
                        default: begin
                            // open loop: nothing is checked; disconnect, duty zero and error are cleared
                            n.disc = 1'b0;
                            n.duty_zero = 1'b0;
                            n.pid_err = 13'h0000;
                        end
                    endcase
                end
            end
            ST_SAMPLE: begin
                if (avg_bus.done) begin
                    n.raw = avg_bus.avg; // RL11
                    n.st = ST_EVAL;
                end
            end
            ST_EVAL: begin
                // threshold checks use the raw value of this period
                n.disc = ({4'h0, r.raw} < r.err_lo) || ({4'h0, r.raw} > r.err_hi); // RL1 RL2
                n.scaled = sc_scaled; // RL3
                n.pid_err = sc_error;
                n.duty_zero = sc_dead; // RL6
                n.int_clr = sc_dead;
                // hardware set wins over a same-cycle software clear
                if (n.disc) begin
                    n.stat[STAT_DISC] = 1'b1;
                end
                n.stat[STAT_DONE] = 1'b1;
                n.st = ST_IDLE;
            end
            default: n.st = ST_IDLE;
        endcase
        n.irq = |(n.stat & n.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.opt <= RST_OPTIONS;
            r.mode <= RST_MODE;
            r.err_lo <= RST_ERR_LO;
            r.err_hi <= RST_ERR_HI;
            r.sc_lo <= RST_SCALE_LO;
            r.sc_hi <= RST_SCALE_HI;
            r.dz <= RST_DEAD_ZONE;
            r.exp <= RST_SAMPLE_EXP;
            r.target <= RST_TARGET;
            r.aux_oe_n <= 1'b1;
            r.rdy <= 1'b1;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // outputs straight from the state register; hresp is tied low
    assign hreadyout = r.rdy;
    assign hrdata = r.hrdata;
    assign hresp = 1'b0;
    assign aux_pin_out = r.aux_out;
    assign aux_pin_oe_n = r.aux_oe_n;
    assign fb_disconnect = r.disc;
    assign duty_zero = r.duty_zero;
    assign integral_clear = r.int_clr;
    assign pid_error = r.pid_err;
    assign scaled_fb = r.scaled;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_err_low_flag: assert property ( // RL1
        clk_en && r.st == ST_EVAL && {4'h0, r.raw} < r.err_lo |=> fb_disconnect && r.stat[0])
        else $error("raw below lower threshold not flagged");
    a_err_high_flag: assert property ( // RL2
        clk_en && r.st == ST_EVAL && {4'h0, r.raw} > r.err_hi |=> fb_disconnect)
        else $error("raw above upper threshold not flagged");
    a_err_in_range: assert property ( // RL1
        clk_en && r.st == ST_EVAL && {4'h0, r.raw} >= r.err_lo
        && {4'h0, r.raw} <= r.err_hi |=> !fb_disconnect)
        else $error("disconnect flagged for a raw value in range");
    a_scale_top: assert property ( // RL3
        clk_en && r.st == ST_EVAL && !r.opt[OPT_INVERT] && r.sc_hi > r.sc_lo
        && {4'h0, r.raw} >= r.sc_hi |=> scaled_fb == FB_FULL)
        else $error("raw at upper bound does not scale to full");
    a_invert_dir: assert property ( // RL4
        clk_en && r.st == ST_EVAL && r.opt[OPT_INVERT] && {4'h0, r.raw} <= r.sc_lo
        |=> scaled_fb == FB_FULL)
        else $error("inverted low end does not scale to full");
    a_aux_drive: assert property ( // RL5
        clk_en && n.opt[OPT_DETECT] |=> !aux_pin_oe_n && !aux_pin_out)
        else $error("sense-power pin not driven low");
    a_dead_zone: assert property ( // RL6
        clk_en && r.st == ST_EVAL && sc_dead
        |=> duty_zero && integral_clear && pid_error == 13'h0000)
        else $error("dead zone did not zero duty and integral");
    a_wrap_short: assert property ( // RL8
        clk_en && r.st == ST_EVAL && r.opt[OPT_WRAP] && r.mode == MODE_ANALOG
        |=> (pid_error[12] ? (13'h0000 - pid_error) : pid_error) <= ERR_HALF)
        else $error("wrapped error takes the long way round");
    a_mode_none: assert property ( // RL9
        clk_en && r.st == ST_IDLE && pid_tick && r.mode != MODE_ANALOG
        && r.mode != MODE_FREQ |=> r.st == ST_IDLE && !duty_zero && !fb_disconnect)
        else $error("mode none still runs feedback");
    a_analog_start: assert property ( // RL7
        clk_en && r.st == ST_IDLE && pid_tick && r.mode == MODE_ANALOG
        |=> r.st == ST_SAMPLE && avg_bus.start)
        else $error("analog period did not start sampling");
    a_eval_source: assert property ( // RL11
        r.st == ST_EVAL && $past(r.st) == ST_IDLE |-> $past(r.mode) == MODE_FREQ)
        else $error("evaluation without a fresh raw value");

    c_disconnect: cover property (clk_en && r.st == ST_EVAL ##1 fb_disconnect);
    c_dead_zone: cover property (integral_clear);
    c_irq_rise: cover property (!irq ##1 irq);
    c_analog_pass: cover property (r.st == ST_SAMPLE ##1 r.st == ST_EVAL);
endmodule

// ==== sim/fbc_pot_model.sv ====
// behavioural feedback potentiometer with its converter on the analog input
module fbc_pot_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [9:0] level,
    input wire logic [9:0] spread,
    output logic adc_valid,
    output logic [9:0] adc_code
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div;
    logic alt;
    // ------------------------------------------------------------
    // conversion pacing
    // ------------------------------------------------------------
    // one conversion every four clocks, alternating level and level-spread;
    // between conversions the code toggles so a stale sample never matches
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div <= 2'h0;
            alt <= 1'b0;
            adc_valid <= 1'b0;
            adc_code <= 10'h000;
        end else begin
            div <= div + 2'h1;
            adc_valid <= (div == 2'h3);
            if (div == 2'h3) begin
                alt <= ~alt;
                adc_code <= alt ? level - spread : level;
            end else begin
                adc_code <= ~adc_code;
            end
        end
    end
endmodule

// ==== sim/fbc_top_tb.sv ====
// self-checking bench for the feedback conditioning block
module fbc_top_tb import fbc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset, hsel, hwrite, pid_tick, adc_valid, hreadyout, hresp;
    logic aux_pin_out, aux_pin_oe_n, fb_disconnect, duty_zero, integral_clear, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] adc_code, level, spread;
    logic [11:0] freq_value, scaled_fb;
    logic [12:0] pid_error;
    int n_errors, checked, n_clears;
    logic [11:0] fv [4] = '{12'h063, 12'h064, 12'hFA0, 12'hFA1};
    logic [11:0] sv [3] = '{12'h1F4, 12'h7D0, 12'hDAC};
    logic [11:0] se [3] = '{12'h000, 12'h7FF, 12'hFFF};
    logic [7:0] ri [9] = '{IDX_OPTIONS, IDX_MODE, IDX_ERR_LO, IDX_ERR_HI, IDX_SCALE_LO,
        IDX_SCALE_HI, IDX_DEAD_ZONE, IDX_SAMPLE_EXP, 8'h10};
    logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'hFFF, 32'h0, 32'hFFF, 32'h0, 32'h7, 32'h0};

    fbc_top u_fbc_top (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pid_tick(pid_tick), .adc_valid(adc_valid), .adc_code(adc_code),
        .freq_value(freq_value), .aux_pin_out(aux_pin_out), .aux_pin_oe_n(aux_pin_oe_n),
        .fb_disconnect(fb_disconnect), .duty_zero(duty_zero),
        .integral_clear(integral_clear), .pid_error(pid_error), .scaled_fb(scaled_fb),
        .irq(irq));
    fbc_pot_model u_fbc_pot_model (.ref_clk(ref_clk), .reset(reset), .level(level),
        .spread(spread), .adc_valid(adc_valid), .adc_code(adc_code));

    // ------------------------------------------------------------
    // clock and pulse counting
    // ------------------------------------------------------------
    always #10 ref_clk = ~ref_clk;
    // counted on the falling edge so the one-cycle pulse is seen exactly once
    always @(negedge ref_clk) if (integral_clear === 1'b1) n_clears++;

    // ------------------------------------------------------------
    // comparison, closing and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // waits for hready with a bound; a hang counts as a mismatch
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // one period: clear the status, tick, then poll the done flag with a bound
    task automatic period();
        int n;
        bus(1'b1, IDX_STATUS, 32'h3);
        pid_tick <= 1'b1;
        @(posedge ref_clk);
        pid_tick <= 1'b0;
        n = 0;
        do begin
            bus(1'b0, IDX_STATUS, 32'h0);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 400);
        if (rd[STAT_DONE] !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic freq(input logic [11:0] v);
        freq_value <= v;
        period();
    endtask
    task automatic analog(input logic [7:0] e, input logic [9:0] lv, input logic [9:0] sp);
        bus(1'b1, IDX_SAMPLE_EXP, {24'h0, e});
        level <= lv;
        spread <= sp;
        period();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {ref_clk, hsel, hwrite, pid_tick, n_errors, checked, n_clears} = '0;
        {haddr, hwdata, htrans, hsize, level, spread, freq_value} = '0;
        reset = 1'b1;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        hsize <= 3'b010;
        @(posedge ref_clk);
        chk(32'({hresp, hreadyout, aux_pin_oe_n}), 32'h3);
        for (int k = 0; k < 9; k++) rd_chk(ri[k], rv[k]);
        bus(1'b1, IDX_ERR_LO, 32'h64);
        bus(1'b1, IDX_ERR_HI, 32'hFA0);
        rd_chk(IDX_ERR_HI, 32'hFA0);
        bus(1'b1, IDX_MODE, 32'h2);
        bus(1'b1, IDX_MASK, 32'h1);
        for (int k = 0; k < 4; k++) begin
            freq(fv[k]);
            chk(32'(fb_disconnect), 32'(fv[k] < 12'h064 || fv[k] > 12'hFA0));
            chk(32'(irq), 32'(fv[k] < 12'h064 || fv[k] > 12'hFA0));
            chk(32'(scaled_fb), 32'(fv[k]));
            chk(32'(pid_error), 32'(13'(13'h0800 - {1'b0, fv[k]})));
        end
        // irq moves on the edge that lands the write, so look one edge later
        bus(1'b1, IDX_MASK, 32'h0);
        @(posedge ref_clk);
        chk(32'(irq), 32'h0);
        bus(1'b1, IDX_MASK, 32'h1);
        @(posedge ref_clk);
        chk(32'(irq), 32'h1);
        bus(1'b1, IDX_STATUS, 32'h1);
        rd_chk(IDX_STATUS, 32'h2);
        bus(1'b1, IDX_MODE, 32'h0);
        pid_tick <= 1'b1;
        @(posedge ref_clk);
        pid_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(32'(fb_disconnect), 32'h0);
        bus(1'b1, IDX_MODE, 32'h2);
        bus(1'b1, IDX_SCALE_LO, 32'h3E8);
        bus(1'b1, IDX_SCALE_HI, 32'hBB8);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, IDX_OPTIONS, i ? 32'h4 : 32'h0);
            for (int k = 0; k < 3; k++) begin
                freq(sv[k]);
                chk(32'(scaled_fb), 32'(i ? 12'hFFF - se[k] : se[k]));
            end
        end
        bus(1'b1, IDX_OPTIONS, 32'h8);
        rd_chk(IDX_OPTIONS, 32'h8);
        chk(32'({aux_pin_oe_n, aux_pin_out}), 32'h0);
        bus(1'b1, IDX_OPTIONS, 32'h0);
        bus(1'b1, IDX_SCALE_LO, 32'h0);
        bus(1'b1, IDX_SCALE_HI, 32'hFFF);
        bus(1'b1, IDX_DEAD_ZONE, 32'hA);
        freq(12'h809);
        chk(32'({duty_zero, pid_error}), 32'h2000);
        chk(32'(n_clears), 32'h1);
        freq(12'h80A);
        chk(32'({duty_zero, pid_error}), 32'h1FF6);
        bus(1'b1, IDX_DEAD_ZONE, 32'h0);
        bus(1'b1, IDX_MODE, 32'h1);
        bus(1'b1, IDX_TARGET, 32'h0);
        analog(8'h2, 10'h3FF, 10'h0);
        rd_chk(IDX_RAW, 32'hFFC);
        chk(32'({fb_disconnect, pid_error}), 32'h3004);
        analog(8'h1, 10'h1F5, 10'h2);
        rd_chk(IDX_RAW, 32'h7D0);
        bus(1'b1, IDX_OPTIONS, 32'h10);
        analog(8'h2, 10'h3FF, 10'h0);
        chk(32'(pid_error), 32'h4);
        rd_chk(IDX_PID_ERR, 32'h4);
        rd_chk(IDX_SCALED, 32'hFFC);
        end_of_test();
    end
endmodule
